// ---- bench/rms_host_asserts.sv ----
// Checker of guard times and pin behaviour of the radio host.
`timescale 1ns/1ns
module rms_host_asserts #(
  parameter int T_ON_XTAL = 200,
  parameter int T_ON_EXTREF = 50,
  parameter int T_SWITCH = 20,
  parameter int BIT_PERIOD = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_ref_used,
  input wire logic tx_request,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_bit,
  input wire logic rx_valid,
  input wire logic rx_bit,
  input wire logic transmit_select,
  input wire logic modulator_data,
  input wire logic demod_data,
  input wire logic radio_ready,
  input wire logic tx_mode
);
  logic [31:0] up;
  logic [31:0] hi_age;
  logic [31:0] lo_age;
  logic [31:0] md_age;
  logic md_last;
  logic strap;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Ages since reset release, since the last edge of the mode pin and of the data pin.
  always_ff @(posedge clk_sys)
  begin
    up <= rst ? 32'h0 : up + 32'h1;
    hi_age <= (rst || !transmit_select) ? 32'h0 : hi_age + 32'h1;
    lo_age <= (rst || transmit_select) ? 32'h0 : lo_age + 32'h1;
    md_age <= (rst || modulator_data != md_last) ? 32'h0 : md_age + 32'h1;
    md_last <= modulator_data;
  end
  // The reference strap as the host catches it on the first edge after reset.
  always_ff @(posedge clk_sys)
  begin
    if (rst || up == 32'h0)
      strap <= ext_ref_used;
  end
  a_settle_hold: assert property (up < T_ON_EXTREF |-> !transmit_select && !rx_valid)
    else $error("early mode or data");
  a_tx_guard: assert property ($rose(tx_mode) |-> hi_age inside {[T_SWITCH:T_SWITCH+1]})
    else $error("tx guard");
  a_rx_guard: assert property ($rose(rx_valid) && lo_age < up
    |-> lo_age inside {[T_SWITCH+1:T_SWITCH+2]}) else $error("rx guard");
  a_sel_follow: assert property ($rose(tx_request) && rx_valid |=> transmit_select)
    else $error("mode pin late");
  a_data_idle: assert property (!tx_mode && !$past(tx_mode) |-> !modulator_data)
    else $error("data not idle");
  a_rx_copy: assert property (rx_valid && $past(rx_valid) |-> rx_bit == $past(demod_data))
    else $error("rx bit");
  a_rx_blank: assert property (!rx_valid |-> !rx_bit)
    else $error("rx bit not blank");
  a_bit_rate: assert property ($changed(modulator_data) && $past(tx_mode)
    |=> $stable(modulator_data)[*3]) else $error("bit too short");
  a_xtal_hold: assert property (!strap && up < T_ON_XTAL |-> !transmit_select && !rx_valid)
    else $error("mode or data before crystal settle");
  a_bit_spacing: assert property ($changed(modulator_data) && transmit_select
    |-> md_age >= BIT_PERIOD - 1) else $error("bit period too short");
  a_reset_idle: assert property ($fell(rst) |-> tx_ready && !transmit_select && !modulator_data)
    else $error("outputs not idle after reset");
endmodule
bind rms_host rms_host_asserts #(.T_ON_XTAL(T_ON_XTAL), .T_ON_EXTREF(T_ON_EXTREF),
  .T_SWITCH(T_SWITCH), .BIT_PERIOD(BIT_PERIOD)) u_chk (.*);

// ---- bench/rms_host_bench.sv ----
// Bench that runs the radio host through power-up, receive and transmit.
`timescale 1ns/1ns
module rms_host_bench;
  localparam int TS = 20;
  localparam int BP = 4;
  logic clk_sys = 0, rst = 1, ext = 0, req = 0, tv = 0, tb = 0, air = 0;
  logic tr, rv, rb, ts, md, dd, rr, tm;
  int num_errors = 0, compares = 0, n;
  rms_host #(.T_ON_XTAL(200), .T_ON_EXTREF(50), .T_SWITCH(TS), .BIT_PERIOD(BP)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .ext_ref_used(ext), .tx_request(req), .tx_valid(tv),
    .tx_ready(tr), .tx_bit(tb), .rx_valid(rv), .rx_bit(rb), .transmit_select(ts),
    .modulator_data(md), .demod_data(dd), .radio_ready(rr), .tx_mode(tm));
  rms_radio_model u_radio (.clk_sys(clk_sys), .transmit_select(ts),
    .modulator_data(md), .air_bit(air), .demod_data(dd));
  // Clock at 100 MHz.
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Counts one settled cycle.
  task tick;
    @(posedge clk_sys);
    #1 n++;
  endtask
  // Reset, then time the settle until receive or transmit select.
  task t_power(input logic e, input int t_on);
    @(posedge clk_sys);
    rst <= 1'b1;
    ext <= e;
    req <= e;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    n = 0;
    do tick; while ((e ? ts : rr) !== 1'b1 && n < 999);
    check("settle", n >= t_on && n <= t_on + 3, 1'b1);
    check("ready after reset", tr, 1'b1);
  endtask
  task t_rx;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys) air <= i[0];
      repeat (3) tick;
      check("rx bit", rb, i[0]);
      check("rx valid", rv, 1'b1);
    end
  endtask
  // Fill the buffer until refused, then send it at the bit rate.
  task t_tx;
    logic [3:0] p;
    p = 4'h9;
    @(posedge clk_sys) tv <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      tb <= p[i];
      @(posedge clk_sys);
    end
    #1 check("full", tr, 1'b0);
    @(posedge clk_sys);
    tv <= 1'b0;
    req <= 1'b1;
    n = 0;
    do tick; while (tm !== 1'b1 && n < 999);
    check("tx guard", n >= TS + 1 && n <= TS + 2, 1'b1);
    check("tx select", ts, 1'b1);
    do tick; while (md !== 1'b1 && n < 999);
    check("first bit", n >= TS + 1 && n <= TS + BP + 1, 1'b1);
    for (int i = 1; i < 5; i++)
    begin
      repeat (BP) tick;
      check("bit", md, p[i > 3 ? 3 : i]);
    end
    check("empty", tr, 1'b1);
  endtask
  task t_back;
    @(posedge clk_sys) req <= 1'b0;
    n = 0;
    do tick; while (rv !== 1'b1 && n < 999);
    check("rx guard", n >= TS + 1 && n <= TS + 3, 1'b1);
    check("idle", md, 1'b0);
    check("rx select", ts, 1'b0);
  endtask
  initial
  begin
    t_power(1'b0, 200);
    t_rx;
    t_tx;
    t_back;
    t_power(1'b1, 50);
    end_of_test;
  end
  // Cuts a hang short.
  initial
  begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule

// ---- bench/rms_radio_model.sv ----
// Pin model of the FSK radio as seen by the host.
`timescale 1ns/1ns
module rms_radio_model (
  input wire logic clk_sys,
  input wire logic transmit_select,
  input wire logic modulator_data,
  input wire logic air_bit,
  output logic demod_data
);
  localparam int SETTLE_CYC = 40;
  logic junk = 1'b0;
  int age = 0;
  wire settled = (age >= SETTLE_CYC);
  // The synthesiser locks some cycles after the run starts; the pattern toggles every cycle.
  always_ff @(posedge clk_sys)
  begin
    junk <= ~junk;
    if (!settled)
      age <= age + 1;
  end
  // Transmit mode or an unlocked synthesiser shows noise, receive mode the carrier bit.
  assign demod_data = (transmit_select || !settled) ? (junk ^ modulator_data) : air_bit;
endmodule

// ---- core/rms_fifo.sv ----
// The transmit bit FIFO module rms_fifo is defined at the end of core/rms_host.sv.

// ---- core/rms_host.sv ----
// Host controller that sequences mode select and serial data of the FSK radio.
`timescale 1ns/1ns
module rms_host
  import rms_pkg::*;
#(
  parameter int unsigned T_ON_XTAL = T_ON_XTAL_CYC,
  parameter int unsigned T_ON_EXTREF = T_ON_EXTREF_CYC,
  parameter int unsigned T_SWITCH = T_SWITCH_CYC,
  parameter int unsigned BIT_PERIOD = BIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_ref_used,
  input wire logic tx_request,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_bit,
  output logic rx_valid,
  output logic rx_bit,
  output logic transmit_select,
  output logic modulator_data,
  input wire logic demod_data,
  output logic radio_ready,
  output logic tx_mode
);
  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  rms_state_t state;
  rms_state_t next_state;
  logic [CNT_W-1:0] guard_cnt;
  logic [CNT_W-1:0] bit_cnt;
  logic ext_ref_latched;
  logic fifo_valid;
  logic fifo_bit;

  // Guard length at power-up depends on the reference strap caught after reset.
  wire [CNT_W-1:0] t_on_cyc = ext_ref_latched ? CNT_W'(T_ON_EXTREF) : CNT_W'(T_ON_XTAL);
  wire [CNT_W-1:0] t_sw_cyc = CNT_W'(T_SWITCH);
  wire guard_done_on = (guard_cnt >= t_on_cyc - 1'b1);
  wire guard_done_sw = (guard_cnt >= t_sw_cyc - 1'b1);
  wire bit_tick = (bit_cnt == CNT_W'(BIT_PERIOD - 1));
  wire in_tx = (state == RMS_TX);
  // A bit leaves the buffer only while transmit goes on, so none is lost at the switch.
  wire stay_tx = (next_state == RMS_TX);
  wire fifo_pop = in_tx && stay_tx && bit_tick && fifo_valid;

  // ----------------------------------------
  // Transmit bit FIFO
  // ----------------------------------------
  rms_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_bit)
  );

  // Next state: power-up guard, then guarded mode switches on tx_request.
  always_comb
  begin
    next_state = state;
    case (state)
      RMS_POWERUP:
        if (guard_done_on)
          next_state = tx_request ? RMS_TX_GUARD : RMS_RX;
      RMS_RX_GUARD:
        if (tx_request)
          next_state = RMS_TX_GUARD;
        else if (guard_done_sw)
          next_state = RMS_RX;
      RMS_RX:
        if (tx_request)
          next_state = RMS_TX_GUARD;
      RMS_TX_GUARD:
        if (!tx_request)
          next_state = RMS_RX_GUARD;
        else if (guard_done_sw)
          next_state = RMS_TX;
      RMS_TX:
        if (!tx_request)
          next_state = RMS_RX_GUARD;
      default:
        next_state = RMS_POWERUP;
    endcase
  end

  // State register; the guard counter restarts on every state change.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= RMS_POWERUP;
      guard_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      guard_cnt <= (next_state != state) ? '0 : guard_cnt + 1'b1;
    end
  end

  // The reference strap is caught on the first clock after reset.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ext_ref_latched <= 1'b0;
    else if (state == RMS_POWERUP && guard_cnt == '0)
      ext_ref_latched <= ext_ref_used;
  end

  // Bit-period divider gives a one-cycle enable at the bit rate, running only in transmit.
  always_ff @(posedge clk_sys)
  begin
    if (rst || !in_tx)
      bit_cnt <= '0;
    else
      bit_cnt <= bit_tick ? '0 : bit_cnt + 1'b1;
  end

  // ----------------------------------------
  // Radio pins
  // ----------------------------------------
  // Mode select is high in the transmit guard and in transmit, low elsewhere.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      transmit_select <= 1'b0;
    else
      transmit_select <= (next_state == RMS_TX_GUARD) || (next_state == RMS_TX);
  end

  // Modulator input idles low on the edge the mode pin falls and holds each bit until the next pop, a period or more later.
  always_ff @(posedge clk_sys)
  begin
    if (rst || !stay_tx)
      modulator_data <= 1'b0;
    else if (fifo_pop)
      modulator_data <= fifo_bit;
  end

  // Demodulated bits pass only in settled receive; 1 is upper deviation.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
      radio_ready <= 1'b0;
      tx_mode <= 1'b0;
    end
    else
    begin
      rx_valid <= (state == RMS_RX);
      rx_bit <= (state == RMS_RX) ? demod_data : 1'b0;
      radio_ready <= (state == RMS_RX) || in_tx;
      tx_mode <= in_tx;
    end
  end
endmodule

// ----------------------------------------
// Bit buffer module
// ----------------------------------------
// Small flip-flop FIFO with valid and ready on both sides.
module rms_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come straight from the fill count; ready holds while a slot is free.
  assign in_ready = (count < (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Storage is written at the write pointer.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers wrap at the depth; the count tracks push and pop together.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ---- core/rms_pkg.sv ----
// Package of timing constants and states for the radio mode sequencer host.
package rms_pkg;
  // ----------------------------------------
  // Clock and guard times
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned T_ON_XTAL_US = 75_000;
  localparam int unsigned T_ON_EXTREF_US = 7_500;
  localparam int unsigned T_SWITCH_US = 3_000;
  localparam int unsigned MAX_BIT_RATE_BPS = 9600;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned T_ON_XTAL_CYC = T_ON_XTAL_US * CYC_PER_US;
  localparam int unsigned T_ON_EXTREF_CYC = T_ON_EXTREF_US * CYC_PER_US;
  localparam int unsigned T_SWITCH_CYC = T_SWITCH_US * CYC_PER_US;
  localparam int unsigned BIT_CYC = (CLK_HZ + MAX_BIT_RATE_BPS - 1) / MAX_BIT_RATE_BPS;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  // Receive, transmit guard, transmit and receive guard form a Gray ring; power-up is one step off it.
  typedef enum logic [2:0] {
    RMS_POWERUP = 3'h4,
    RMS_RX = 3'h0,
    RMS_TX_GUARD = 3'h1,
    RMS_TX = 3'h3,
    RMS_RX_GUARD = 3'h2
  } rms_state_t;
endpackage
